//--- core/qdf_frontend.sv
// Purpose: filter, edge select, swap and decode quadrature inputs with position and stall watchdog
// Assumes: encoder pins asynchronous to sys_clk; control bits static or quasi-static
// Notes: capture path only gets its selected phase; timestamp logic lives elsewhere
`timescale 1ns/1ns

module qdf_frontend #(
    parameter int FLT_W = qdf_pkg::FLT_WIDTH,
    parameter int POS_W = qdf_pkg::POS_WIDTH,
    parameter int WDT_W = qdf_pkg::WDT_WIDTH
) (
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic firstQuadratureInput,
    input wire logic secondQuadratureInput,
    input wire logic indexInput,
    input wire logic encoderEnable,
    input wire logic encoderMode,
    input wire logic noiseFilterEnable,
    input wire logic [2:0] inputFilterSelect,
    input wire logic [2:0] inputEdgePolarity,
    input wire logic phaseSwapSelect,
    input wire logic [FLT_W-1:0] glitchFilterLength,
    input wire logic [WDT_W-1:0] watchdogCompare,
    input wire logic phaseErrorClear,
    output logic loadPulse,
    output logic upDown,
    output logic phaseError,
    output logic [POS_W-1:0] position,
    output logic watchdogTimeout,
    output logic captureSignal,
    output logic indexSignal
);
    // widths past 32 would outgrow the reset constants; settle count fits three bits
    if (FLT_W < 2 || POS_W < 2 || WDT_W < 2 || POS_W > 32 || WDT_W > 32
            || qdf_pkg::SETTLE_CYCLES > 7) begin : g_bad_param
        $error("qdf_frontend: unsupported width");
    end

    // ----------------------------------------
    // synchronisers
    // ----------------------------------------
    logic [2:0] syncFirst;
    logic [2:0] syncSecond;
    logic [2:0] rawIn;
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            syncFirst <= 3'h0;
            syncSecond <= 3'h0;
        end else begin
            syncFirst <= {indexInput, secondQuadratureInput, firstQuadratureInput};
            syncSecond <= syncFirst;
        end
    end
    assign rawIn = syncSecond;

    // pin levels are unknown to the decoder when reset lifts; hold decode off
    // until both flops and the filters carry real levels, else a false edge counts
    // limitation: a pin edge inside this short window is absorbed, not counted
    logic [2:0] settleCount;
    logic settled;
    assign settled = (settleCount == 3'(qdf_pkg::SETTLE_CYCLES));
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            settleCount <= 3'h0;
        end else if (!settled) begin
            settleCount <= settleCount + 3'h1;
        end
    end

    // ----------------------------------------
    // noise filters
    // ----------------------------------------
    // a new level must stand longer than length plus two cycles before it passes
    logic [2:0] filtered;
    genvar gi;
    generate
        for (gi = 0; gi < 3; gi++) begin : g_filter
            logic held;
            logic [FLT_W:0] stable;
            logic useFilter;
            assign useFilter = noiseFilterEnable && inputFilterSelect[gi];
            always_ff @(posedge sys_clk or negedge rstn) begin
                if (!rstn) begin
                    held <= 1'b0;
                    stable <= '0;
                end else if (!useFilter || !settled || rawIn[gi] == held) begin
                    held <= rawIn[gi];
                    stable <= '0;
                end else if (stable >= {1'b0, glitchFilterLength} + (FLT_W+1)'(qdf_pkg::FLT_EXTRA)) begin
                    held <= rawIn[gi];
                    stable <= '0;
                end else begin
                    stable <= stable + (FLT_W+1)'(1);
                end
            end
            assign filtered[gi] = useFilter ? held : rawIn[gi];
        end
    endgenerate

    // ----------------------------------------
    // edge select and swap
    // ----------------------------------------
    logic [2:0] polar;
    logic first_quadrature_input;
    logic second_quadrature_input;
    assign polar = filtered ^ ~inputEdgePolarity;
    assign first_quadrature_input = phaseSwapSelect ? polar[1] : polar[0];
    assign second_quadrature_input = phaseSwapSelect ? polar[0] : polar[1];

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            captureSignal <= 1'b0;
            indexSignal <= 1'b0;
        end else begin
            captureSignal <= first_quadrature_input && (encoderMode == qdf_pkg::QDF_MODE_CAPTURE);
            indexSignal <= polar[2];
        end
    end

    // ----------------------------------------
    // direction decoding
    // ----------------------------------------
    logic active;
    logic [1:0] prevState;
    logic [1:0] curState;
    logic [1:0] change;
    logic next_upDown;
    assign active = settled && encoderEnable && (encoderMode == qdf_pkg::QDF_MODE_ENCODER);
    assign curState = {first_quadrature_input, second_quadrature_input};
    assign change = curState ^ prevState;

    // leading A: a moving A takes the level B does not hold, a moving B takes A's level
    function automatic logic dir_of(input logic [1:0] prev, input logic [1:0] cur, input logic oldDir);
        logic d;
        d = oldDir;
        if (cur[1] != prev[1]) begin
            d = (cur[1] != prev[0]);
        end else if (cur[0] != prev[0]) begin
            d = (cur[0] == prev[1]);
        end
        return d;
    endfunction : dir_of

    always_comb begin
        next_upDown = upDown;
        if (change == 2'h3) begin
            next_upDown = upDown;
        end else if (change != 2'h0) begin
            next_upDown = dir_of(prevState, curState, upDown);
        end
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            prevState <= qdf_pkg::PHASE_RESET;
            upDown <= 1'b1;
            loadPulse <= 1'b0;
        end else begin
            prevState <= curState;
            loadPulse <= active && (change == 2'h1 || change == 2'h2);
            if (active) begin
                upDown <= next_upDown;
            end
        end
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            phaseError <= 1'b0;
        end else if (active && change == 2'h3) begin
            phaseError <= 1'b1;
        end else if (phaseErrorClear || !encoderEnable) begin
            phaseError <= 1'b0;
        end
    end

    // ----------------------------------------
    // position and watchdog
    // ----------------------------------------
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            position <= qdf_pkg::POS_RESET[POS_W-1:0];
        end else if (loadPulse) begin
            position <= upDown ? position + POS_W'(1) : position - POS_W'(1);
        end
    end

    // counts only while decoding, so capture mode never reports a stall
    logic [WDT_W-1:0] wdtCount;
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            wdtCount <= qdf_pkg::WDT_RESET[WDT_W-1:0];
            watchdogTimeout <= 1'b0;
        end else begin
            wdtCount <= (loadPulse || !active) ? '0 : wdtCount + WDT_W'(1);
            if (loadPulse || !active) begin
                watchdogTimeout <= 1'b0;
            end else if (wdtCount == watchdogCompare) begin
                watchdogTimeout <= 1'b1;
            end
        end
    end

    // ----------------------------------------
    // checks
    // ----------------------------------------
    sequence s_double;
        active && change == 2'h3;
    endsequence
    sequence s_single;
        active && $countones(change) == 1;
    endsequence
    property p_err_set;
        @(posedge sys_clk) disable iff (!rstn) s_double |=> phaseError;
    endproperty
    a_err_set: assert property (p_err_set) else $error("phase error not set");
    property p_dir_hold;
        @(posedge sys_clk) disable iff (!rstn) s_double |=> $stable(upDown) && !loadPulse;
    endproperty
    a_dir_hold: assert property (p_dir_hold) else $error("direction moved on double edge");
    property p_load_edge;
        @(posedge sys_clk) disable iff (!rstn) s_single |=> loadPulse;
    endproperty
    a_load_edge: assert property (p_load_edge) else $error("missing load pulse");
    property p_load_single;
        @(posedge sys_clk) disable iff (!rstn) loadPulse && !(active && $countones(change) == 1) |=> !loadPulse;
    endproperty
    a_load_single: assert property (p_load_single) else $error("load pulse too long");
    property p_pos_up;
        @(posedge sys_clk) disable iff (!rstn) loadPulse && upDown |=> position == $past(position) + POS_W'(1);
    endproperty
    a_pos_up: assert property (p_pos_up) else $error("position did not increment");
    property p_pos_down;
        @(posedge sys_clk) disable iff (!rstn) loadPulse && !upDown |=> position == $past(position) - POS_W'(1);
    endproperty
    a_pos_down: assert property (p_pos_down) else $error("position did not decrement");
    property p_wdt_clear;
        @(posedge sys_clk) disable iff (!rstn) loadPulse |=> wdtCount == '0 && !watchdogTimeout;
    endproperty
    a_wdt_clear: assert property (p_wdt_clear) else $error("watchdog not cleared");
    property p_wdt_fire;
        @(posedge sys_clk) disable iff (!rstn) active && !loadPulse && wdtCount == watchdogCompare |=> watchdogTimeout;
    endproperty
    a_wdt_fire: assert property (p_wdt_fire) else $error("watchdog did not fire");
    property p_no_decode_capture;
        @(posedge sys_clk) disable iff (!rstn) encoderMode == qdf_pkg::QDF_MODE_CAPTURE |=> !loadPulse;
    endproperty
    a_no_decode_capture: assert property (p_no_decode_capture) else $error("decode in capture mode");
    property p_up_lead;
        @(posedge sys_clk) disable iff (!rstn) active && prevState == 2'h0 && curState == 2'h2 |=> upDown;
    endproperty
    a_up_lead: assert property (p_up_lead) else $error("lead not counted up");
    property p_down_lag;
        @(posedge sys_clk) disable iff (!rstn) active && prevState == 2'h0 && curState == 2'h1 |=> !upDown;
    endproperty
    a_down_lag: assert property (p_down_lag) else $error("lag not counted down");
    property p_idle_quiet;
        @(posedge sys_clk) disable iff (!rstn) active && change == 2'h0 |=> !loadPulse;
    endproperty
    a_idle_quiet: assert property (p_idle_quiet) else $error("load pulse without edge");
    // set beats clear in one cycle, so only a cycle with no double edge clears
    property p_err_clear;
        @(posedge sys_clk) disable iff (!rstn)
            !(active && change == 2'h3) && (phaseErrorClear || !encoderEnable) |=> !phaseError;
    endproperty
    a_err_clear: assert property (p_err_clear) else $error("phase error not cleared");
    property p_err_sticky;
        @(posedge sys_clk) disable iff (!rstn) phaseError && !phaseErrorClear && encoderEnable |=> phaseError;
    endproperty
    a_err_sticky: assert property (p_err_sticky) else $error("phase error dropped");
    property p_capture_sel;
        @(posedge sys_clk) disable iff (!rstn)
            encoderMode == qdf_pkg::QDF_MODE_CAPTURE |=> captureSignal == $past(first_quadrature_input);
    endproperty
    a_capture_sel: assert property (p_capture_sel) else $error("capture phase wrong");
    property p_capture_off;
        @(posedge sys_clk) disable iff (!rstn) encoderMode == qdf_pkg::QDF_MODE_ENCODER |=> !captureSignal;
    endproperty
    a_capture_off: assert property (p_capture_off) else $error("capture active in encoder mode");
    property p_inactive_quiet;
        @(posedge sys_clk) disable iff (!rstn) !active |=> !loadPulse && !watchdogTimeout;
    endproperty
    a_inactive_quiet: assert property (p_inactive_quiet) else $error("activity while decode off");
    property p_timeout_hold;
        @(posedge sys_clk) disable iff (!rstn) watchdogTimeout && active && !loadPulse |=> watchdogTimeout;
    endproperty
    a_timeout_hold: assert property (p_timeout_hold) else $error("watchdog timeout dropped");
    property p_wdt_count;
        @(posedge sys_clk) disable iff (!rstn) active && !loadPulse |=> wdtCount == $past(wdtCount) + WDT_W'(1);
    endproperty
    a_wdt_count: assert property (p_wdt_count) else $error("watchdog not counting");
endmodule : qdf_frontend

//--- core/qdf_pkg.sv
// Purpose: shared constants for the quadrature decoder front end
// Assumes: 100 MHz peripheral clock in the documented device, 125 MHz here
// Notes: times kept in their own units, cycle counts derived below
package qdf_pkg;
    localparam int CLK_PERIOD_PS = 8000;
    localparam int PCLK_PERIOD_PS = 10000;
    localparam longint GLITCH_REJECT_PS = 64'h0000_0004_A817_C800;
    // counter width for up to 20 ms of noise at the clock period
    localparam int FLT_WIDTH = $clog2(GLITCH_REJECT_PS / CLK_PERIOD_PS);
    localparam int FLT_EXTRA = 2;
    localparam int POS_WIDTH = 32;
    localparam int WDT_WIDTH = 32;
    localparam int SYNC_STAGES = 2;
    // decode stays off this many cycles after reset while pin levels settle
    localparam int SETTLE_CYCLES = SYNC_STAGES + 2;
    localparam logic [1:0] PHASE_RESET = 2'h0;
    localparam logic [31:0] POS_RESET = 32'h0000_0000;
    localparam logic [31:0] WDT_RESET = 32'h0000_0000;
    typedef enum logic {
        QDF_MODE_ENCODER,
        QDF_MODE_CAPTURE
    } qdf_mode_type;
endpackage : qdf_pkg

//--- sim/qdf_encoder_model.sv
// Purpose: behavioural shaft encoder driving two phases and index
// Assumes: bench calls the tasks; pins move just after a rising edge
// Notes: pins are push-pull, so no released state exists
`timescale 1ns/1ns
module qdf_encoder_model (
    input wire logic sys_clk,
    output logic pinA,
    output logic pinB,
    output logic pinIdx
);
    logic [1:0] phase = 2'h0;
    initial begin
        pinA = 1'b0;
        pinB = 1'b0;
        pinIdx = 1'b1;
    end
    // gray order: one phase moves per step; a jump of two is the fault case
    task automatic move(input logic [1:0] nxt);
        @(posedge sys_clk);
        #1;
        phase = nxt;
        pinA = nxt[0] ^ nxt[1];
        pinB = nxt[1];
        pinIdx = (nxt == 2'h0);
    endtask : move
    task automatic step(input logic fwd);
        move(fwd ? phase + 2'h1 : phase - 2'h1);
    endtask : step
endmodule : qdf_encoder_model

//--- sim/testbench.sv
// Purpose: self-checking bench for the quadrature front end
// Assumes: default parameters; filter length 3 when filtering
// Notes: loads counted on every edge from the registered pulse
`timescale 1ns/1ns
module testbench;
    typedef struct packed {
        logic mode; logic swap; logic [2:0] pol; logic flt;
        logic fwd; logic [2:0] n; logic [31:0] delta; logic dir;
    } qdf_row_type;
    localparam qdf_row_type ROWS [7] = '{
        '{1'h0, 1'h0, 3'h3, 1'h0, 1'h1, 3'h4, 32'h0000_0004, 1'h1},
        '{1'h0, 1'h0, 3'h7, 1'h0, 1'h0, 3'h4, 32'hFFFF_FFFC, 1'h0},
        '{1'h0, 1'h1, 3'h7, 1'h0, 1'h1, 3'h4, 32'hFFFF_FFFC, 1'h0},
        '{1'h0, 1'h0, 3'h6, 1'h0, 1'h1, 3'h4, 32'hFFFF_FFFC, 1'h0},
        '{1'h0, 1'h0, 3'h7, 1'h1, 1'h1, 3'h4, 32'h0000_0004, 1'h1},
        '{1'h1, 1'h0, 3'h7, 1'h0, 1'h1, 3'h1, 32'h0000_0000, 1'h0},
        '{1'h1, 1'h1, 3'h7, 1'h0, 1'h1, 3'h1, 32'h0000_0000, 1'h0}};
    logic sys_clk = 1'b0;
    logic rstn = 1'b0;
    logic encoderMode = 1'b0;
    logic encoderEnable = 1'b1;
    logic noiseFilterEnable = 1'b0;
    logic [2:0] inputFilterSelect = 3'h0;
    logic [2:0] inputEdgePolarity = 3'h7;
    logic phaseSwapSelect = 1'b0;
    logic phaseErrorClear = 1'b0;
    logic pinA, pinB, pinIdx, loadPulse, upDown, phaseError, watchdogTimeout, captureSignal, indexSignal;
    logic [31:0] position, base;
    logic dir0;
    int n_fail = 0;
    int num_checks = 0;
    int loads = 0;
    int cnt;
    qdf_row_type r;
    always #4 sys_clk = ~sys_clk;
    always @(posedge sys_clk) if (loadPulse === 1'b1) loads++;
    qdf_encoder_model enc (.sys_clk(sys_clk), .pinA(pinA), .pinB(pinB), .pinIdx(pinIdx));
    qdf_frontend uut (.sys_clk(sys_clk), .rstn(rstn), .firstQuadratureInput(pinA),
        .secondQuadratureInput(pinB), .indexInput(pinIdx), .encoderEnable(encoderEnable), .encoderMode(encoderMode),
        .noiseFilterEnable(noiseFilterEnable), .inputFilterSelect(inputFilterSelect),
        .inputEdgePolarity(inputEdgePolarity), .phaseSwapSelect(phaseSwapSelect),
        .glitchFilterLength(22'h0003), .watchdogCompare(32'h0000_0014), .phaseErrorClear(phaseErrorClear),
        .loadPulse(loadPulse), .upDown(upDown), .phaseError(phaseError), .position(position),
        .watchdogTimeout(watchdogTimeout), .captureSignal(captureSignal), .indexSignal(indexSignal));
    task automatic wc(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask : wc
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask : check
    task automatic print_verdict();
        if (n_fail == 0 && num_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : print_verdict
    // -------------------------------------------------------------
    // main sequence
    // -------------------------------------------------------------
    initial begin
        wc(10);
        rstn = 1'b1;
        for (int i = 0; i < 7; i++) begin
            r = ROWS[i];
            encoderMode = r.mode;
            phaseSwapSelect = r.swap;
            inputEdgePolarity = r.pol;
            noiseFilterEnable = r.flt;
            inputFilterSelect = {3{r.flt}};
            // config change may itself look like an edge, so settle first
            wc(30);
            base = position;
            loads = 0;
            repeat (r.n) begin
                enc.step(r.fwd);
                wc(12);
            end
            wc(20);
            check("loads", loads, r.mode ? 0 : r.n);
            check("position", position - base, r.delta);
            if (!r.mode) check("upDown", upDown, r.dir);
            else check("capture", captureSignal, (r.swap ? pinB : pinA) == r.pol[r.swap]);
            check("index", indexSignal, pinIdx == r.pol[2]);
        end
        encoderMode = 1'b0;
        wc(30);
        enc.step(1'b1);
        for (cnt = 0; loadPulse !== 1'b1 && cnt < 10; cnt++) wc(1);
        check("latency", cnt, 3);
        // a timeout left from the settle wait stands until the pulse clears it
        wc(1);
        for (cnt = 0; watchdogTimeout !== 1'b1 && cnt < 100; cnt++) wc(1);
        check("wdtSpan", cnt >= 19 && cnt <= 23, 1);
        enc.step(1'b1);
        wc(6);
        check("wdtClear", watchdogTimeout, 0);
        for (int j = 0; j < 3; j++) begin
            noiseFilterEnable = (j < 2);
            inputFilterSelect = 3'h7;
            wc(30);
            loads = 0;
            enc.move(enc.phase ^ 2'h1);
            wc(j == 0 ? 4 : (j == 1 ? 5 : 1));
            enc.move(enc.phase ^ 2'h1);
            wc(30);
            check("glitch", loads, j == 0 ? 0 : 2);
        end
        noiseFilterEnable = 1'b0;
        dir0 = upDown;
        loads = 0;
        enc.move(enc.phase + 2'h2);
        wc(10);
        check("errLoads", loads, 0);
        check("errFlag", phaseError, 1);
        check("errDir", upDown, dir0);
        phaseErrorClear = 1'b1;
        wc(1);
        phaseErrorClear = 1'b0;
        wc(3);
        check("errClear", phaseError, 0);
        enc.move(enc.phase + 2'h2);
        wc(10);
        check("errFlag2", phaseError, 1);
        encoderEnable = 1'b0;
        loads = 0;
        wc(2);
        check("errOff", phaseError, 0);
        check("wdtOff", watchdogTimeout, 0);
        enc.step(1'b1);
        wc(10);
        check("offLoads", loads, 0);
        encoderEnable = 1'b1;
        wc(10);
        // pins now stand off their reset levels, so a careless decoder sees a false edge
        rstn = 1'b0;
        wc(3);
        rstn = 1'b1;
        loads = 0;
        wc(1);
        check("rstState", {upDown, loadPulse, phaseError, watchdogTimeout}, 4'h8);
        check("rstPos", position, 0);
        wc(10);
        check("rstLoads", loads, 0);
        check("rstErr", phaseError, 0);
        check("rstPos2", position, 0);
        print_verdict();
    end
    // watchdog sized well past the fewer than a thousand cycles the tests take
    initial begin
        repeat (20000) @(posedge sys_clk);
        n_fail++;
        print_verdict();
    end
endmodule : testbench
